//--- hdl/ccod_core.sv
// control cpu: fetch, decode and execute of the opcode set
// assumes a program rom and device-selected ports sharing one data bus
//
// Overview of operation
// - opcode 00 selects binary increment of working register
// - opcode 02 selects decimal increment
// - opcode 01 selects binary decrement
// - opcode C3 selects decimal decrement
// - load immediate fetches next byte into working register
// - load_from_register copies selected register to working
// - store_to_register writes working into selected register
// - port_input reads selected port onto working register
// - port_output_immediate sends next byte to port
// - register_store_immediate puts next byte in register
// - two-byte instructions other than jump and call advance pc past both bytes
// - return variant restores pc and re-enables interrupts
// - call_indirect saves return, jumps to indirect target
// - jump_indirect branches indirectly, saves nothing
// - octal 137 is idle_op, only pc advances
`timescale 1ns/1ps
`include "ccod_map.svh"

module ccod_core
#(
	parameter logic [`CCOD_ADDR_W-1:0] IRQ_VECTOR = 11'h0FF
)
(
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               srst,
	// program rom
	output ccod_pkg::ccod_addr_t     pgm_addr,
	output logic                     pgm_rd,
	// shared data bus, three-signal form
	input  wire logic [7:0]         data_in,
	output logic [7:0]               data_out,
	output logic                     data_oe_n,
	// device-selected ports
	output logic [3:0]               port_select,
	output logic                     port_rd,
	output logic                     port_wr,
	// interrupt request, asynchronous
	input  wire logic               irq_req,
	output logic                     int_enabled
);
	import ccod_pkg::*;

	if (IRQ_VECTOR == {`CCOD_ADDR_W{1'b1}})
	begin : g_bad_vector
		$error("vector must leave room for the following byte");
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] >= 4'h9)
		begin
			r[3:0] = 4'h0;
			r[7:4] = (v[7:4] >= 4'h9) ? 4'h0 : v[7:4] + 4'h1;
		end
		else
		begin
			r[3:0] = v[3:0] + 4'h1;
		end
		return r;
	endfunction

	function automatic logic [7:0] bcd_dec(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == 4'h0)
		begin
			r[3:0] = 4'h9;
			r[7:4] = (v[7:4] == 4'h0) ? 4'h9 : v[7:4] - 4'h1;
		end
		else
		begin
			r[3:0] = v[3:0] - 4'h1;
		end
		return r;
	endfunction

	function automatic logic skip_true(input logic [2:0] c, input logic [7:0] a,
		input logic [7:0] r0);
		logic t;
		t = 1'b0;
		case (c)
			`CCOD_SK_GT: t = a > r0;
			`CCOD_SK_LT: t = a < r0;
			`CCOD_SK_EQ: t = a == r0;
			`CCOD_SK_AZ: t = a == `CCOD_BYTE_ZERO;
			`CCOD_SK_LE: t = a <= r0;
			`CCOD_SK_GE: t = a >= r0;
			`CCOD_SK_NE: t = a != r0;
			`CCOD_SK_AN: t = a != `CCOD_BYTE_ZERO;
			default:     t = 1'b0;
		endcase
		return t;
	endfunction

	// ****************************************
	// state
	// ****************************************
	ccod_state_s cur_reg;
	ccod_state_s cur_next;
	logic        bus_ready;
	logic [7:0]  bus_byte;

	assign bus_ready = cur_reg.cnt == `CCOD_BUS_WAIT;
	assign bus_byte  = cur_reg.din_s2;

	always_comb
	begin
		cur_next = cur_reg;
		// data and irq pins cross in through two flops before use
		cur_next.din_s1 = data_in;
		cur_next.din_s2 = cur_reg.din_s1;
		cur_next.irq_s1 = irq_req;
		cur_next.irq_s2 = cur_reg.irq_s1;
		case (cur_reg.state)
			ST_FETCH:
			begin
				if (cur_reg.cnt == `CCOD_CNT_ZERO && cur_reg.int_en && cur_reg.irq_s2)
				begin
					// vector taken before fetch, no half-read opcode to undo
					cur_next.int_ret = cur_reg.pc;
					cur_next.pc      = IRQ_VECTOR;
					cur_next.int_en  = 1'b0;
				end
				else if (bus_ready)
				begin
					cur_next.op    = bus_byte;
					cur_next.cnt   = 2'h0;
					cur_next.state = ST_DECODE;
				end
				else
				begin
					cur_next.cnt = cur_reg.cnt + `CCOD_CNT_ONE;
				end
			end
			ST_DECODE:
			begin
				cur_next.state = ST_FETCH;
				cur_next.pc    = cur_reg.pc + `CCOD_PC_ONE;
				if (cur_reg.op == `CCOD_OP_INC_BIN)
					cur_next.working_register = cur_reg.working_register + `CCOD_BYTE_ONE;
				else if (cur_reg.op == `CCOD_OP_INC_DEC)
					cur_next.working_register = bcd_inc(cur_reg.working_register);
				else if (cur_reg.op == `CCOD_OP_DEC_BIN)
					cur_next.working_register = cur_reg.working_register - `CCOD_BYTE_ONE;
				else if (cur_reg.op == `CCOD_OP_DEC_DEC)
					cur_next.working_register = bcd_dec(cur_reg.working_register);
				else if (cur_reg.op == `CCOD_OP_CLR)
					cur_next.working_register = `CCOD_BYTE_ZERO;
				else if (cur_reg.op == `CCOD_OP_CMPL)
					cur_next.working_register = ~cur_reg.working_register;
				else if (cur_reg.op == `CCOD_OP_SHL)
					cur_next.working_register = {cur_reg.working_register[6:0], 1'b0};
				else if (cur_reg.op == `CCOD_OP_SHR)
					cur_next.working_register = {1'b0, cur_reg.working_register[7:1]};
				else if (cur_reg.op == `CCOD_OP_IDLE)
					cur_next.pc = cur_reg.pc + `CCOD_PC_ONE;
				else if (cur_reg.op == `CCOD_OP_INT_EN)
					cur_next.int_en = 1'b1;
				else if (cur_reg.op == `CCOD_OP_INT_DIS)
					cur_next.int_en = 1'b0;
				else if (cur_reg.op == `CCOD_OP_RET_SUB)
					cur_next.pc = cur_reg.sub_ret;
				else if (cur_reg.op == `CCOD_OP_RET_INT)
					cur_next.pc = cur_reg.int_ret;
				else if (cur_reg.op == `CCOD_OP_RET_INTE)
				begin
					cur_next.pc     = cur_reg.int_ret;
					cur_next.int_en = 1'b1;
				end
				else if (cur_reg.op[7:3] == `CCOD_GRP_SKIP)
				begin
					// a taken skip passes a two-byte slot
					if (skip_true(cur_reg.op[2:0], cur_reg.working_register, cur_reg.regs[0]))
						cur_next.pc = cur_reg.pc + `CCOD_PC_TWO + `CCOD_PC_ONE;
				end
				else if (cur_reg.op[7:3] == `CCOD_GRP_JUMP_IND)
					cur_next.pc = {cur_reg.op[2:0], cur_reg.working_register};
				else if (cur_reg.op[7:3] == `CCOD_GRP_CALL_IND)
				begin
					cur_next.sub_ret = cur_reg.pc + `CCOD_PC_ONE;
					cur_next.pc      = {cur_reg.op[2:0], cur_reg.working_register};
				end
				else if (cur_reg.op[7:4] == `CCOD_GRP_LOAD_REG)
					cur_next.working_register = cur_reg.regs[cur_reg.op[3:0]];
				else if (cur_reg.op[7:4] == `CCOD_GRP_STORE)
					cur_next.regs[cur_reg.op[3:0]] = cur_reg.working_register;
				else if (cur_reg.op[7:4] == `CCOD_GRP_PORT_IN)
				begin
					cur_next.port_select = cur_reg.op[3:0];
					cur_next.pc          = cur_reg.pc;
					cur_next.state       = ST_PORT;
				end
				else if (cur_reg.op[7:4] == `CCOD_GRP_PORT_OUT)
				begin
					cur_next.port_select = cur_reg.op[3:0];
					cur_next.dout        = cur_reg.working_register;
					cur_next.state       = ST_WRITE;
				end
				else if (cur_reg.op == `CCOD_OP_LOAD_IMM
					|| cur_reg.op[7:4] == `CCOD_GRP_PORT_IMM
					|| cur_reg.op[7:4] == `CCOD_GRP_REG_IMM
					|| cur_reg.op[7:3] == `CCOD_GRP_JUMP
					|| cur_reg.op[7:3] == `CCOD_GRP_CALL)
					cur_next.state = ST_OPER;
			end
			ST_OPER:
			begin
				if (bus_ready)
				begin
					cur_next.cnt   = 2'h0;
					cur_next.state = ST_FETCH;
					cur_next.pc    = cur_reg.pc + `CCOD_PC_ONE;
					if (cur_reg.op == `CCOD_OP_LOAD_IMM)
						cur_next.working_register = bus_byte;
					else if (cur_reg.op[7:4] == `CCOD_GRP_PORT_IMM)
					begin
						cur_next.port_select = cur_reg.op[3:0];
						cur_next.dout        = bus_byte;
						cur_next.state       = ST_WRITE;
					end
					else if (cur_reg.op[7:4] == `CCOD_GRP_REG_IMM)
						cur_next.regs[cur_reg.op[3:0]] = bus_byte;
					else
					begin
						if (cur_reg.op[7:3] == `CCOD_GRP_CALL)
							cur_next.sub_ret = cur_reg.pc + `CCOD_PC_ONE;
						cur_next.pc = {cur_reg.op[2:0], bus_byte};
					end
				end
				else
				begin
					cur_next.cnt = cur_reg.cnt + `CCOD_CNT_ONE;
				end
			end
			ST_WRITE:
			begin
				cur_next.state = ST_FETCH;
			end
			ST_PORT:
			begin
				if (bus_ready)
				begin
					cur_next.working_register = bus_byte;
					cur_next.cnt              = 2'h0;
					cur_next.pc               = cur_reg.pc + `CCOD_PC_ONE;
					cur_next.state            = ST_FETCH;
				end
				else
				begin
					cur_next.cnt = cur_reg.cnt + `CCOD_CNT_ONE;
				end
			end
			default:
			begin
				cur_next.state = ST_FETCH;
				cur_next.cnt   = 2'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cur_reg       <= '0;
			cur_reg.state <= ST_FETCH;
			cur_reg.pc    <= `CCOD_PC_RST;
		end
		else
		begin
			cur_reg <= cur_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign pgm_addr    = cur_reg.pc;
	assign pgm_rd      = cur_reg.state == ST_FETCH || cur_reg.state == ST_OPER;
	assign data_out    = cur_reg.dout;
	assign data_oe_n   = cur_reg.state != ST_WRITE;
	assign port_select = cur_reg.port_select;
	assign port_rd     = cur_reg.state == ST_PORT;
	assign port_wr     = cur_reg.state == ST_WRITE;
	assign int_enabled = cur_reg.int_en;

endmodule // ccod_core

//--- include/ccod_map.svh
// opcode patterns, widths and timing counts for the control cpu decoder
// assumes an 8-bit opcode byte and an 11-bit program address
`ifndef CCOD_MAP_SVH
`define CCOD_MAP_SVH

`define CCOD_ADDR_W      11
`define CCOD_PC_RST      11'h000
`define CCOD_PC_ONE      11'h001
`define CCOD_PC_TWO      11'h002
`define CCOD_BUS_WAIT    2'h2
`define CCOD_CNT_ONE     2'h1
`define CCOD_CNT_ZERO    2'h0
`define CCOD_BYTE_ZERO   8'h00
`define CCOD_BYTE_ONE    8'h01

// whole-byte opcodes: accumulator, load immediate, idle, interrupt enable and returns
`define CCOD_OP_INC_BIN  8'h00
`define CCOD_OP_DEC_BIN  8'h01
`define CCOD_OP_INC_DEC  8'h02
`define CCOD_OP_CLR      8'h04
`define CCOD_OP_CMPL     8'h05
`define CCOD_OP_SHL      8'h06
`define CCOD_OP_SHR      8'h07
`define CCOD_OP_DEC_DEC  8'hC3
`define CCOD_OP_LOAD_IMM 8'hDF
`define CCOD_OP_IDLE     8'h5F
`define CCOD_OP_INT_EN   8'h2F
`define CCOD_OP_INT_DIS  8'hAF
`define CCOD_OP_RET_SUB  8'hB8
`define CCOD_OP_RET_INT  8'hB0
`define CCOD_OP_RET_INTE 8'hB1

// upper nibble groups, low nibble is register or port select; five-bit groups, low three bits are skip code or address high bits
`define CCOD_GRP_PORT_IN  4'h4
`define CCOD_GRP_PORT_OUT 4'h5
`define CCOD_GRP_LOAD_REG 4'h6
`define CCOD_GRP_STORE    4'h7
`define CCOD_GRP_PORT_IMM 4'hC
`define CCOD_GRP_REG_IMM  4'hD
`define CCOD_GRP_SKIP     5'h01
`define CCOD_GRP_JUMP     5'h10
`define CCOD_GRP_CALL     5'h11
`define CCOD_GRP_JUMP_IND 5'h12
`define CCOD_GRP_CALL_IND 5'h13

// skip condition codes, low three bits of the skip group
`define CCOD_SK_GT  3'h0
`define CCOD_SK_LT  3'h1
`define CCOD_SK_EQ  3'h2
`define CCOD_SK_AZ  3'h3
`define CCOD_SK_LE  3'h4
`define CCOD_SK_GE  3'h5
`define CCOD_SK_NE  3'h6
`define CCOD_SK_AN  3'h7

`endif

//--- include/ccod_pkg.sv
// types for the control cpu decoder
// assumes ccod_map.svh is on the include path
`include "ccod_map.svh"
package ccod_pkg;
	typedef logic [`CCOD_ADDR_W-1:0] ccod_addr_t;

	// gray sequence fetch -> decode -> operand -> write, port read off decode
	typedef enum logic [2:0]
	{
		ST_FETCH  = 3'h0,
		ST_DECODE = 3'h1,
		ST_OPER   = 3'h3,
		ST_WRITE  = 3'h2,
		ST_PORT   = 3'h6
	} ccod_state_e;

	typedef struct packed
	{
		ccod_state_e      state;
		logic [1:0]       cnt;
		ccod_addr_t       pc;
		ccod_addr_t       sub_ret;
		ccod_addr_t       int_ret;
		logic             int_en;
		logic [7:0]       working_register;
		logic [15:0][7:0] regs;
		logic [7:0]       op;
		logic [7:0]       din_s1;
		logic [7:0]       din_s2;
		logic             irq_s1;
		logic             irq_s2;
		logic [3:0]       port_select;
		logic [7:0]       dout;
	} ccod_state_s;
endpackage

//--- tb/ccod_core_asserts.sv
// port checker for the decoder core
// assumes it is bound onto every ccod_core instance
`timescale 1ns/1ps
module ccod_core_asserts
(
	// watched ports
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire ccod_pkg::ccod_addr_t pgm_addr,
	input wire logic                 pgm_rd,
	input wire logic [3:0]           port_select,
	input wire logic                 port_rd,
	input wire logic                 port_wr,
	input wire logic                 data_oe_n,
	input wire logic                 int_enabled
);
	import ccod_pkg::*;
	// ****************************************
	// bus sequencing
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_wr_pulse:
		assert property (port_wr |-> !data_oe_n ##1 (data_oe_n && !port_wr)) else $error("bad write");
	chk_oe_cause:
		assert property (!data_oe_n |-> port_wr) else $error("bus driven without write");
	chk_rd_excl:
		assert property (port_rd |-> !pgm_rd && data_oe_n) else $error("port read overlap");
	chk_port_len:
		assert property ($rose(port_rd) |-> port_rd[*3] ##1 (!port_rd && pgm_rd))
			else $error("port read length");
	chk_sel_hold:
		assert property (port_rd && $past(port_rd) |-> $stable(port_select))
			else $error("select moved in read");
	chk_after_dec:
		assert property ($fell(pgm_rd) |=> pgm_rd || port_rd || port_wr) else $error("idle decode");
	chk_fetch_len:
		assert property ($rose(pgm_rd) |-> pgm_rd[*3]) else $error("short fetch");
	chk_addr_hold:
		assert property ($rose(pgm_rd) && !int_enabled |=> $stable(pgm_addr)[*2])
			else $error("address moved in fetch");
endmodule // ccod_core_asserts

bind ccod_core ccod_core_asserts u_chk (.ref_clk(ref_clk), .srst(srst), .pgm_addr(pgm_addr),
	.pgm_rd(pgm_rd), .port_select(port_select), .port_rd(port_rd), .port_wr(port_wr),
	.data_oe_n(data_oe_n), .int_enabled(int_enabled));

//--- tb/ccod_far_model.sv
// program rom and input ports sharing the data bus
// assumes the bench fills rom and in_port directly
`timescale 1ns/1ps
module ccod_far_model
(
	// bus side
	input wire logic                 ref_clk,
	input wire ccod_pkg::ccod_addr_t pgm_addr,
	input wire logic                 pgm_rd,
	input wire logic [3:0]           port_select,
	input wire logic                 port_rd,
	input wire logic [7:0]           data_out,
	input wire logic                 data_oe_n,
	output logic [7:0]               data_in
);
	import ccod_pkg::*;
	logic [7:0] rom [2048];
	logic [7:0] in_port [16];
	logic [7:0] last_reg;
	// released bus shows a changing pattern, never a stale byte
	always_comb
	begin
		if (!data_oe_n)
			data_in = data_out;
		else if (pgm_rd)
			data_in = rom[pgm_addr];
		else if (port_rd)
			data_in = in_port[port_select];
		else
			data_in = ~last_reg;
	end
	always @(posedge ref_clk)
		last_reg <= data_in;
endmodule // ccod_far_model

//--- tb/control_cpu_opcode_decoder_tb_top.sv
// bench for the decoder core: runs small programs from the far model
// assumes ccod_map.svh on the include path
`timescale 1ns/1ps
`include "ccod_map.svh"
module control_cpu_opcode_decoder_tb_top;
	import ccod_pkg::*;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        irq_req = 1'b0;
	ccod_addr_t  pgm_addr;
	logic        pgm_rd, data_oe_n, port_rd, port_wr, int_enabled;
	logic [7:0]  data_in, data_out;
	logic [3:0]  port_select;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [11:0] wq [$];
	always #20 ref_clk = ~ref_clk;
	ccod_core #(.IRQ_VECTOR(11'h0FF)) dut (.ref_clk(ref_clk), .srst(srst), .pgm_addr(pgm_addr),
		.pgm_rd(pgm_rd), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.port_select(port_select), .port_rd(port_rd), .port_wr(port_wr), .irq_req(irq_req),
		.int_enabled(int_enabled));
	ccod_far_model far (.ref_clk(ref_clk), .pgm_addr(pgm_addr), .pgm_rd(pgm_rd),
		.port_select(port_select), .port_rd(port_rd), .data_out(data_out),
		.data_oe_n(data_oe_n), .data_in(data_in));
	// ****************************************
	// shared tasks
	// ****************************************
	always @(posedge ref_clk)
		if (port_wr === 1'b1 && srst === 1'b0)
			wq.push_back({port_select, data_out});
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp)
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			miscompares++;
	endtask
	// unused rom reads as idle so a stray pc shows as missing writes
	task automatic hold();
		srst <= 1'b1;
		irq_req <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 2048; i++)
			far.rom[i] = `CCOD_OP_IDLE;
		wq.delete();
	endtask
	task automatic go();
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
	endtask
	task automatic ld(input int a, input logic [7:0] b [$]);
		foreach (b[i])
			far.rom[a + i] = b[i];
	endtask
	task automatic wait_w(input int n);
		for (int t = 0; t < 8000 && wq.size() < n; t++)
			@(posedge ref_clk);
		if (wq.size() < n)
		begin
			miscompares++;
			results();
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_arith();
		hold();
		ld(0, {8'hC3, 8'h51, 8'hDF, 8'h09, 8'h02, 8'h51, 8'h00, 8'h51, 8'h01, 8'h51, 8'hC3, 8'h51});
		go();
		wait_w(5);
		check(wq[0], 12'h199);
		check(wq[1], 12'h110);
		check(wq[2], 12'h111);
		check(wq[3], 12'h110);
		check(wq[4], 12'h109);
	endtask
	task automatic t_regs();
		hold();
		far.in_port[6] = 8'hC4;
		ld(0, {8'hD3, 8'h5A, 8'h63, 8'h52, 8'hDF, 8'h3C, 8'h74, 8'hDF, 8'h00, 8'h64});
		ld(10, {8'h5F, 8'h52, 8'h46, 8'h56, 8'hC7, 8'hA5});
		go();
		wait_w(4);
		check(wq[0], 12'h25A);
		check(wq[1], 12'h23C);
		check(wq[2], 12'h6C4);
		check(wq[3], 12'h7A5);
	endtask
	task automatic t_skip();
		logic [7:0]  a [3] = '{8'h41, 8'h00, 8'h40};
		logic [7:0]  v;
		logic [7:0]  m;
		int          p = 2;
		logic [11:0] e [$];
		hold();
		ld(0, {8'hD0, 8'h40});
		foreach (a[i])
			for (int c = 0; c < 8; c++)
			begin
				v = a[i];
				m = {v != 0, v != 8'h40, v >= 8'h40, v <= 8'h40, v == 0, v == 8'h40, v < 8'h40,
					v > 8'h40};
				ld(p, {8'hDF, v, 8'(8'h08 + c), 8'hC1, 8'h01, 8'hC1, 8'h02});
				p += 7;
				if (!m[c])
					e.push_back(12'h101);
				e.push_back(12'h102);
			end
		go();
		wait_w(e.size());
		foreach (e[k])
			check(wq[k], e[k]);
	endtask
	task automatic t_jump();
		hold();
		ld(0, {8'hDF, 8'h20, 8'h91});
		ld(11'h120, {8'hDF, 8'h40, 8'h9B, 8'hC1, 8'h55, 8'h8A, 8'h51, 8'h83, 8'h10});
		ld(11'h340, {8'hC1, 8'h44, 8'hB8});
		// a return one byte short would run the 51 operand and write 140
		ld(11'h251, {8'hC1, 8'h66, 8'hB8});
		ld(11'h310, {8'hC1, 8'h77});
		go();
		wait_w(4);
		check(wq[0], 12'h144);
		check(wq[1], 12'h155);
		check(wq[2], 12'h166);
		check(wq[3], 12'h177);
	endtask
	task automatic t_irq();
		hold();
		ld(0, {8'h2F});
		ld(11'h0FF, {8'hC1, 8'h77, 8'hB1});
		irq_req <= 1'b1;
		go();
		wait_w(1);
		irq_req <= 1'b0;
		check(wq[0], 12'h177);
		for (int t = 0; t < 60 && !(int_enabled === 1'b1 && pgm_addr === 11'h001); t++)
			@(posedge ref_clk);
		check({int_enabled, pgm_addr}, 12'h801);
	endtask
	initial
	begin
		t_arith();
		t_regs();
		t_skip();
		t_jump();
		t_irq();
		results();
	end
endmodule // control_cpu_opcode_decoder_tb_top
